// File: rtl/ugf_map.svh
`ifndef UGF_MAP_SVH
`define UGF_MAP_SVH

// Register byte offsets on the Wishbone slave
`define UGF_ADR_CTRL 8'h00
`define UGF_ADR_STATUS 8'h04
`define UGF_ADR_CHG_MAP 8'h08
`define UGF_ADR_PIN_IN 8'h0C
`define UGF_ADR_PIN_CFG_BASE 8'h40

// Control register fields
`define UGF_CTRL_APPLY_BIT 0

// Status register fields
`define UGF_STAT_VBUS_BIT 0
`define UGF_STAT_PULLUP_BIT 1
`define UGF_STAT_CHG_LSB 2
`define UGF_STAT_CFG_BIT 4
`define UGF_STAT_SUSP_BIT 5
`define UGF_STAT_PRESS_LSB 8
`define UGF_STAT_TOUCH_LSB 16

// Pin configuration register fields
`define UGF_CFG_FUNC_LSB 0
`define UGF_CFG_SEL_LSB 4

// Reset values: code per class 0..3 is 00, 01, 10, 11
`define UGF_CHG_MAP_RST 8'hE4

// Sizes
`define UGF_TOUCH_MAX 8
`define UGF_PRESS_W 4

`endif

// File: rtl/ugf_pin_mux.sv
`timescale 1ns/1ps
`include "ugf_map.svh"

module ugf_pin_mux
    import ugf_pkg::*;
(
    // Configuration of this pin
    input wire ugf_pin_cfg_type cfg_i,
    // Shared function sources
    input wire ugf_usb_type usb_i,
    input wire logic [1:0] chg_code_i,
    input wire logic [`UGF_PRESS_W-1:0] pressed_i,
    // Next pin drive
    output logic out_o,
    output logic oe_o
);

    // One function per pin, chosen by the stored code
    always_comb
    begin
        out_o = 1'b0;
        oe_o = 1'b1;
        unique case (cfg_i.func)
            UGF_FN_DRIVE1: out_o = 1'b1; // R12
            UGF_FN_DRIVE0: out_o = 1'b0; // R12
            UGF_FN_POWER_N: out_o = ~usb_i.configured | usb_i.suspend; // R1
            UGF_FN_TX_LED: out_o = ~usb_i.tx_busy; // R2
            UGF_FN_RX_LED: out_o = ~usb_i.rx_busy; // R3
            UGF_FN_ANY_LED: out_o = ~(usb_i.tx_busy | usb_i.rx_busy); // R4
            UGF_FN_CHG_BIT0: out_o = chg_code_i[0]; // R5
            UGF_FN_CHG_BIT1: out_o = chg_code_i[1]; // R5
            UGF_FN_PRESSED_OUT: out_o = pressed_i[cfg_i.sel[1:0]]; // R11
            // Inputs, high-impedance and illegal codes never drive
            default: oe_o = 1'b0; // R12
        endcase
    end

endmodule

// File: rtl/ugf_pkg.sv
`include "ugf_map.svh"

package ugf_pkg;

    // Pin functions; codes above the last one are illegal and act as high-impedance
    typedef enum logic [3:0] {
        UGF_FN_HIZ,
        UGF_FN_DRIVE1,
        UGF_FN_DRIVE0,
        UGF_FN_POWER_N,
        UGF_FN_TX_LED,
        UGF_FN_RX_LED,
        UGF_FN_ANY_LED,
        UGF_FN_CHG_BIT0,
        UGF_FN_CHG_BIT1,
        UGF_FN_VBUS_SENSE,
        UGF_FN_TOUCH_IN,
        UGF_FN_PRESSED_OUT
    } ugf_func_type;

    // One pin's configuration byte: selector picks button or code bit
    typedef struct packed {
        logic [3:0] sel;
        ugf_func_type func;
    } ugf_pin_cfg_type;

    // Indications from the USB device core
    typedef struct packed {
        logic configured;
        logic suspend;
        logic tx_busy;
        logic rx_busy;
    } ugf_usb_type;

    // Charger kind reported by the detection logic
    typedef enum logic [1:0] {
        UGF_CHG_NONE,
        UGF_CHG_SDP,
        UGF_CHG_CDP,
        UGF_CHG_DCP
    } ugf_chg_kind_type;

endpackage

// File: rtl/ugf_top.sv
// Operation
// R1 - Power-gate pin low only when configured, unsuspended
// R2 - Transmit LED pin low during USB transmit
// R3 - Receive LED pin low during USB receive
// R4 - Combined LED pin low during either traffic
// R5 - Two charger pins show remappable two-bit class code
// R6 - VBUS-sense pin is an input detecting VBUS
// R7 - VBUS present enables D+ pull-up
// R8 - VBUS absent removes D+ pull-up
// R9 - All pins high-impedance while reset asserted
// R10 - Up to eight pins act as touch inputs
// R11 - Up to four pins encode pressed button
// R12 - Hi_z_option pin undriven; static pins constant level
// R13 - Stored configuration selects one function per pin
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "ugf_map.svh"

module ugf_top
    import ugf_pkg::*;
#(
    parameter int NUM_PINS = 17,
    parameter int ADR_W = 8,
    parameter logic [NUM_PINS*8-1:0] CFG_DEFAULT = '0
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // USB device core indications
    input wire ugf_usb_type usb_i,
    input wire ugf_chg_kind_type chg_kind_i,
    // General-purpose pins
    input wire logic [NUM_PINS-1:0] pin_i,
    output logic [NUM_PINS-1:0] pin_o,
    output logic [NUM_PINS-1:0] pin_oe_o,
    // USB D+ pull-up control
    output logic dp_pullup_en_o
);

    // Whole module state in one record
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [7:0] chg_map;
        ugf_pin_cfg_type [NUM_PINS-1:0] shadow;
        ugf_pin_cfg_type [NUM_PINS-1:0] active;
        logic [NUM_PINS-1:0] pin_in;
        logic vbus;
        logic [`UGF_TOUCH_MAX-1:0] touched;
        logic [`UGF_PRESS_W-1:0] pressed;
        logic [1:0] chg_code;
        logic [NUM_PINS-1:0] out;
        logic [NUM_PINS-1:0] oe;
    } ugf_state_type;

    ugf_state_type state_reg;
    ugf_state_type state_next;

    logic [NUM_PINS-1:0] mux_out;
    logic [NUM_PINS-1:0] mux_oe;
    logic [31:0] read_value;
    logic bus_req;
    logic vbus_any;
    logic vbus_sensed;
    logic [`UGF_TOUCH_MAX-1:0] touch_vec;
    logic [`UGF_PRESS_W-1:0] press_code;
    logic [1:0] chg_class;

    // One function mux per pin
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1)
        begin : g_pin
            ugf_pin_mux i_ugf_pin_mux (
                .cfg_i(state_reg.active[gi]),
                .usb_i(usb_i),
                .chg_code_i(state_reg.chg_code),
                .pressed_i(state_reg.pressed),
                .out_o(mux_out[gi]),
                .oe_o(mux_oe[gi])
            );
        end
    endgenerate

    // A new request is one not yet answered
    assign bus_req = wb_cyc_i & wb_stb_i & ~state_reg.ack;

    // Gather sense and touch inputs from the pins holding those functions
    always_comb
    begin
        vbus_any = 1'b0;
        vbus_sensed = 1'b0;
        touch_vec = '0;
        for (int i = 0; i < NUM_PINS; i++)
        begin
            if (state_reg.active[i].func == UGF_FN_VBUS_SENSE) // R6
            begin
                vbus_any = 1'b1;
                vbus_sensed = vbus_sensed | state_reg.pin_in[i]; // R6
            end
            if (state_reg.active[i].func == UGF_FN_TOUCH_IN) // R10
            begin
                touch_vec[state_reg.active[i].sel[2:0]] =
                    touch_vec[state_reg.active[i].sel[2:0]] | state_reg.pin_in[i]; // R10
            end
        end
    end

    // Lowest pressed button wins; code 0 means none pressed
    always_comb
    begin
        press_code = '0;
        for (int b = `UGF_TOUCH_MAX - 1; b >= 0; b--)
        begin
            if (state_reg.touched[b])
            begin
                press_code = 4'(b + 1); // R11
            end
        end
    end

    // Charger class: 0 no VBUS or unconfigured, 1 configured (any kind but CDP or DCP), 2 CDP or DCP, 3 suspend
    always_comb
    begin
        chg_class = 2'h0;
        if (!state_reg.vbus)
        begin
            chg_class = 2'h0; // R5
        end
        else if (usb_i.suspend)
        begin
            chg_class = 2'h3; // R5
        end
        else if (chg_kind_i == UGF_CHG_CDP || chg_kind_i == UGF_CHG_DCP)
        begin
            chg_class = 2'h2; // R5
        end
        else if (usb_i.configured)
        begin
            chg_class = 2'h1; // R5
        end
    end

    // Register read multiplexer; unmapped words read zero
    always_comb
    begin
        read_value = '0;
        unique case (wb_adr_i)
            `UGF_ADR_CTRL: read_value = '0;
            `UGF_ADR_STATUS:
            begin
                read_value[`UGF_STAT_VBUS_BIT] = state_reg.vbus;
                read_value[`UGF_STAT_PULLUP_BIT] = dp_pullup_en_o;
                read_value[`UGF_STAT_CHG_LSB +: 2] = state_reg.chg_code;
                read_value[`UGF_STAT_CFG_BIT] = usb_i.configured;
                read_value[`UGF_STAT_SUSP_BIT] = usb_i.suspend;
                read_value[`UGF_STAT_PRESS_LSB +: `UGF_PRESS_W] = state_reg.pressed;
                read_value[`UGF_STAT_TOUCH_LSB +: `UGF_TOUCH_MAX] = state_reg.touched;
            end
            `UGF_ADR_CHG_MAP: read_value[7:0] = state_reg.chg_map;
            `UGF_ADR_PIN_IN: read_value[NUM_PINS-1:0] = state_reg.pin_in;
            default:
            begin
                for (int i = 0; i < NUM_PINS; i++)
                begin
                    if (wb_adr_i == ADR_W'(`UGF_ADR_PIN_CFG_BASE + 4 * i))
                    begin
                        read_value[7:0] = state_reg.shadow[i];
                    end
                end
            end
        endcase
    end

    // Next-state logic for bus, configuration and pin drive
    always_comb
    begin
        state_next = state_reg;
        state_next.ack = bus_req;
        state_next.rdat = '0;
        if (bus_req && !wb_we_i)
        begin
            state_next.rdat = read_value;
        end
        // Register writes take effect on the accepting edge
        if (bus_req && wb_we_i && wb_sel_i[0])
        begin
            if (wb_adr_i == `UGF_ADR_CTRL && wb_dat_i[`UGF_CTRL_APPLY_BIT])
            begin
                state_next.active = state_reg.shadow; // R13
            end
            if (wb_adr_i == `UGF_ADR_CHG_MAP)
            begin
                state_next.chg_map = wb_dat_i[7:0]; // R5
            end
            for (int i = 0; i < NUM_PINS; i++)
            begin
                if (wb_adr_i == ADR_W'(`UGF_ADR_PIN_CFG_BASE + 4 * i))
                begin
                    state_next.shadow[i] = wb_dat_i[7:0]; // R13
                end
            end
        end
        // Inputs arrive synchronous; one stage aligns them with the config
        state_next.pin_in = pin_i;
        // Without a sense pin the chip can only run from VBUS itself
        state_next.vbus = vbus_any ? vbus_sensed : 1'b1; // R6
        state_next.touched = touch_vec; // R10
        state_next.pressed = press_code; // R11
        state_next.chg_code = state_reg.chg_map[2 * chg_class +: 2]; // R5
        state_next.out = mux_out;
        state_next.oe = mux_oe; // R12
    end

    // State register; reset loads the stored startup configuration
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= '0;
            state_reg.chg_map <= `UGF_CHG_MAP_RST; // R5
            state_reg.shadow <= CFG_DEFAULT; // R13
            state_reg.active <= CFG_DEFAULT; // R13
            state_reg.vbus <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Bus answers come straight from the state record
    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = state_reg.rdat;

    // Gated by reset itself so pins float even before the first edge
    assign pin_o = state_reg.out;
    assign pin_oe_o = state_reg.oe & {NUM_PINS{~rst_i}}; // R9

    // Pull-up follows detected VBUS; removed when absent to stop back-current
    assign dp_pullup_en_o = state_reg.vbus & ~rst_i; // R7 R8

endmodule

// File: tb/test_usb_bridge_gpio_function_outputs.sv
`timescale 1ns/1ps
`include "ugf_map.svh"

module test_usb_bridge_gpio_function_outputs
    import ugf_pkg::*;
;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic [7:0] adr = 8'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] q;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic dp_pullup_en_o;
    ugf_usb_type usb_i = 4'h0;
    ugf_chg_kind_type chg_kind_i = UGF_CHG_NONE;
    logic [16:0] pin_i;
    logic [16:0] pin_o;
    logic [16:0] pin_oe_o;
    logic [16:0] ext = 17'h0;
    int n_mismatch = 0;
    int n_tests = 0;

    // Clock
    always #2.5 clk_i = ~clk_i;

    ugf_top i_ugf_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .usb_i(usb_i), .chg_kind_i(chg_kind_i), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o), .dp_pullup_en_o(dp_pullup_en_o));
    ugf_far_side i_ugf_far_side (.drv_i(pin_o), .oe_i(pin_oe_o), .ext_i(ext), .lvl_o(pin_i));

    task report_and_stop;
        $display("Counts: %0d tests, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task check(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // Classic cycle; entered just after an edge, leaves one idle cycle
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_mismatch++;
            report_and_stop;
        end
        q = wb_dat_o;
        cyc <= 0;
        stb <= 0;
        @(posedge clk_i);
    endtask

    task t_map;
        wb(0, `UGF_ADR_CHG_MAP, 32'h0);
        check(q, 32'hE4);
        wb(0, 8'h3C, 32'h0);
        check(q, 32'h0);
        $display("t_map done");
    endtask

    // Pin k gets function k; touch and pressed pins use button and bit 0
    task t_config;
        for (int k = 0; k < 12; k++)
            wb(1, 8'(`UGF_ADR_PIN_CFG_BASE + 4 * k), 32'(k));
        // Pin 12 gets an illegal code, which must leave it undriven
        wb(1, 8'(`UGF_ADR_PIN_CFG_BASE + 4 * 12), 32'hF);
        wb(1, `UGF_ADR_CTRL, 32'h1);
        repeat (3) @(posedge clk_i);
        check(pin_oe_o, 17'h09FE);
        check(pin_o[2:1], 2'h1);
        $display("t_config done");
    endtask

    task t_usb;
        for (int u = 0; u < 16; u++)
        begin
            usb_i <= ugf_usb_type'(4'(u));
            repeat (3) @(posedge clk_i);
            check(pin_o[6:3], {~(u[1] | u[0]), ~u[0], ~u[1], ~u[3] | u[2]});
        end
        $display("t_usb done");
    endtask

    task chg(input logic v, input logic [3:0] u, input ugf_chg_kind_type k, input logic [1:0] e);
        ext[9] <= v;
        usb_i <= ugf_usb_type'(u);
        chg_kind_i <= k;
        repeat (6) @(posedge clk_i);
        check({dp_pullup_en_o, pin_o[8:7]}, {v, e});
    endtask

    task t_chg;
        chg(0, 4'h8, UGF_CHG_SDP, 2'h0);
        chg(1, 4'h8, UGF_CHG_NONE, 2'h1);
        chg(1, 4'h8, UGF_CHG_CDP, 2'h2);
        chg(1, 4'h8, UGF_CHG_DCP, 2'h2);
        chg(1, 4'hC, UGF_CHG_DCP, 2'h3);
        chg(1, 4'h0, UGF_CHG_NONE, 2'h0);
        wb(1, `UGF_ADR_CHG_MAP, 32'h1B);
        chg(1, 4'hC, UGF_CHG_NONE, 2'h0);
        chg(1, 4'h8, UGF_CHG_SDP, 2'h2);
        $display("t_chg done");
    endtask

    task t_touch;
        ext[10] <= 1;
        repeat (6) @(posedge clk_i);
        check(pin_o[11], 1'b1);
        wb(0, `UGF_ADR_STATUS, 32'h0);
        check({q[23:16], q[11:8]}, 12'h011);
        ext[10] <= 0;
        repeat (6) @(posedge clk_i);
        check(pin_o[11], 1'b0);
        $display("t_touch done");
    endtask

    // Reset while pins drive; startup config is all high-impedance
    // With no sense pin left, VBUS counts as present and the pull-up returns
    task t_rerst;
        rst_i <= 1;
        @(posedge clk_i);
        @(posedge clk_i);
        check({dp_pullup_en_o, pin_oe_o}, 18'h0);
        rst_i <= 0;
        repeat (3) @(posedge clk_i);
        check({dp_pullup_en_o, pin_oe_o}, 18'h20000);
        $display("t_rerst done");
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk_i);
        check({dp_pullup_en_o, pin_oe_o}, 18'h0);
        rst_i <= 0;
        @(posedge clk_i);
        t_map();
        t_config();
        t_usb();
        t_chg();
        t_touch();
        t_rerst();
        report_and_stop;
    end
endmodule

// File: tb/ugf_far_side.sv
`timescale 1ns/1ps

module ugf_far_side #(
    parameter int N = 17
)
(
    // Device pin drive
    input wire logic [N-1:0] drv_i,
    input wire logic [N-1:0] oe_i,
    // Levels the board puts on pins the device leaves free
    input wire logic [N-1:0] ext_i,
    // Resolved pin level
    output logic [N-1:0] lvl_o
);
    // Device wins where it drives; VBUS divider and buttons elsewhere
    assign lvl_o = (drv_i & oe_i) | (ext_i & ~oe_i);
endmodule

// File: tb/ugf_top_assertions.sv
`timescale 1ns/1ps

module ugf_top_checker #(
    parameter int NUM_PINS = 17
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Pin drive
    input wire logic [NUM_PINS-1:0] pin_oe_o,
    input wire logic dp_pullup_en_o
);
    // A request is taken only while no answer is pending
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence bus_ans;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    rst_hiz_a: assert property (@(posedge clk_i) rst_i |-> pin_oe_o == '0)
        else $error("pin driven during reset");
    rst_pullup_a: assert property (@(posedge clk_i) rst_i |-> !dp_pullup_en_o)
        else $error("pull-up on during reset");
    ack_rst_a: assert property (@(posedge clk_i) rst_i |=> !wb_ack_o)
        else $error("ack during reset");
    ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i) bus_req |=> bus_ans)
        else $error("request not answered by one ack");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than a cycle");
    ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    dat_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    // Functions change only on reset or an apply write, never by themselves
    oe_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(pin_oe_o) |-> $past(rst_i) || $past(rst_i, 2) || $past(wb_ack_o)
        || $past(wb_ack_o, 2) || $past(wb_ack_o, 3)) else $error("pin enable changed alone");
endmodule

bind ugf_top ugf_top_checker #(.NUM_PINS(NUM_PINS)) i_ugf_top_checker (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .pin_oe_o(pin_oe_o), .dp_pullup_en_o(dp_pullup_en_o));
